/* File: hw/ppr_pkg.sv */
// constants, offsets and decode types of the parallel port register block
// assumes one 125 MHz clock domain; host pins are synchronised in the top
package ppr_pkg;

	localparam int unsigned CLK_MHZ = 125;
	localparam int unsigned SYNC_STAGES = 2;

	// printed register offsets, three-bit host address
	localparam logic [2:0] OFS_DATA      = 3'h0;
	localparam logic [2:0] OFS_STATUS    = 3'h1;
	localparam logic [2:0] OFS_CONTROL   = 3'h2;
	localparam logic [2:0] OFS_INDEX     = 3'h3;
	localparam logic [2:0] OFS_FP_DATA0  = 3'h4;
	localparam logic [2:0] OFS_FP_DATA1  = 3'h5;
	localparam logic [2:0] OFS_FP_ADDR   = 3'h6;
	localparam logic [2:0] OFS_INDIRECT  = 3'h7;

	// control register fields
	localparam int unsigned CTL_STROBE_BIT  = 0;
	localparam int unsigned CTL_AUTOFD_BIT  = 1;
	localparam int unsigned CTL_INIT_BIT    = 2;
	localparam int unsigned CTL_SELIN_BIT   = 3;
	localparam int unsigned CTL_IRQEN_BIT   = 4;
	localparam int unsigned CTL_DIR_BIT     = 5;
	localparam logic [2:0]  CTL_READ_ONES   = 3'h7;

	// status register fields
	localparam int unsigned STS_INT_BIT     = 2;
	localparam logic [1:0]  STS_LOW_ONES    = 2'h3;

	// mode selection register fields
	localparam int unsigned MODE_EXT_BIT    = 1;
	localparam int unsigned MODE_INTSEL_BIT = 2;
	localparam int unsigned MODE_FPEN_BIT   = 4;

	// indirect index values
	localparam int unsigned BANK_REGS      = 6;
	localparam logic [2:0]  IDX_MODE       = 3'h5;
	localparam logic [2:0]  IDX_VERSION    = 3'h6;
	localparam logic [2:0]  IDX_PARK       = 3'h7;
	localparam logic [7:0]  PARK_READ      = 8'hFF;

	// reset values
	localparam logic [7:0] DATA_RESET  = 8'h00;
	localparam logic [5:0] CTL_RESET   = 6'h00;
	localparam logic [7:0] INDEX_RESET = 8'h00;
	localparam logic [7:0] BANK_RESET  = 8'h00;
	localparam logic [7:0] FP_RESET    = 8'h00;

	typedef enum logic [2:0] {
		SEL_DATA,
		SEL_STATUS,
		SEL_CONTROL,
		SEL_INDEX,
		SEL_FP_DATA,
		SEL_FP_ADDR,
		SEL_INDIRECT
	} ppr_sel_t;

endpackage

/* File: hw/ppr_sync.sv */
// two-flop synchroniser for a bundle of asynchronous pins
// assumes each bit is an independent level; bundles are not coherent
`timescale 1ns/1ps
`default_nettype none
module ppr_sync #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic             mclk,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;

	always_ff @(posedge mclk) begin
		if (srst) begin
			stage1_reg <= '0;
			stage2_reg <= '0;
		end else begin
			stage1_reg <= din;
			stage2_reg <= stage1_reg;
		end
	end

	assign dout = stage2_reg;
endmodule
`default_nettype wire

/* File: hw/ppr_indirect_bank.sv */
// indirectly reached registers: six setup registers, version and parking slot
// assumes write pulses and index come from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module ppr_indirect_bank
	import ppr_pkg::*;
#(
	// arbitrary neutral version value
	parameter logic [7:0] VERSION_VALUE = 8'h5A
) (
	input  wire logic       mclk,
	input  wire logic       srst,
	input  wire logic       wrPulse,
	input  wire logic [2:0] index,
	input  wire logic [7:0] wrData,
	output logic      [7:0] rdData,
	output logic      [7:0] modeSel
);
	logic [7:0] bank_reg  [BANK_REGS];
	logic [7:0] bank_next [BANK_REGS];

	always_comb begin
		for (int i = 0; i < BANK_REGS; i++) begin
			bank_next[i] = bank_reg[i];
		end
		if (wrPulse && (index < IDX_VERSION)) begin
			bank_next[index] = wrData;
		end
	end

	always_ff @(posedge mclk) begin
		for (int i = 0; i < BANK_REGS; i++) begin
			bank_reg[i] <= srst ? BANK_RESET : bank_next[i];
		end
	end

	always_comb begin
		if (index < IDX_VERSION) begin
			rdData = bank_reg[index];
		end else if (index == IDX_VERSION) begin
			rdData = VERSION_VALUE;
		end else begin
			rdData = PARK_READ;
		end
	end

	assign modeSel = bank_reg[IDX_MODE];

	parkWrite_a: assert property (@(posedge mclk) disable iff (srst)
		wrPulse && (index >= IDX_VERSION) |=> $stable(modeSel))
		else $error("write to version or parking slot changed a register");
endmodule
`default_nettype wire

/* File: hw/ppr_port_regs.sv */
// parallel port host register block: decode, data, status, control, index
// assumes asynchronous host strobes and printer pins; all are synchronised here
//
// Contract
// - decode only while chip select is low
// - fast port off: bit 2 ignored, 7 indirect
// - fast port on, index not 7: 4-5 data, 6 address
// - fast port on, index 7: 4 to 7 data
// - mode bit 4 low disables the fast port
// - offset 7 reaches register chosen by index
// - data register read/write, resets to zero
// - status write ignored; bits 7:3 show pins
// - status bit 2 interrupt if mode bit 2
// - status bits 1 and 0 read one
// - control write drives lines and irq enable
// - control read: bits 4:0 back, 7:5 ones
// - control bit 4 enables the port interrupt
// - extended mode direction from pin and direction bit
// - direction bit only counts in extended mode
// - index register read/write, low bits select, reset zero
`timescale 1ns/1ps
`default_nettype none
module ppr_port_regs
	import ppr_pkg::*;
#(
	parameter logic [7:0] VERSION_VALUE = 8'h5A
) (
	input  wire logic       mclk,
	input  wire logic       srst,
	input  wire logic       port_chip_select_n,
	input  wire logic       ioReadN,
	input  wire logic       ioWriteN,
	input  wire logic [2:0] addr,
	input  wire logic [7:0] hostDataIn,
	output logic      [7:0] hostDataOut,
	output logic            hostDataOe,
	input  wire logic [7:0] portDataIn,
	output logic      [7:0] portDataOut,
	output logic            portDataOe,
	input  wire logic       busyPin,
	input  wire logic       ackPinN,
	input  wire logic       paperEnd,
	input  wire logic       printerSelected,
	input  wire logic       errorPin,
	input  wire logic       bidirEnablePin,
	output logic            lineStrobe,
	output logic            lineAutofeed,
	output logic            lineInitialize,
	output logic            lineSelectIn,
	output logic            portIrq,
	output logic            fastPortEnable
);
	localparam int unsigned SYNC_W = 28;

	function automatic ppr_sel_t decodeSel(
		input logic [2:0] a,
		input logic       fpOn,
		input logic       idxAll1
	);
		ppr_sel_t s;
		s = SEL_DATA;
		if (a == OFS_INDIRECT) begin
			s = (fpOn && idxAll1) ? SEL_FP_DATA : SEL_INDIRECT;
		end else if (a == OFS_INDEX) begin
			s = SEL_INDEX;
		end else if (!fpOn || !a[2]) begin
			if (a[1:0] == OFS_DATA[1:0]) begin
				s = SEL_DATA;
			end else if (a[1:0] == OFS_STATUS[1:0]) begin
				s = SEL_STATUS;
			end else begin
				s = SEL_CONTROL;
			end
		end else if (idxAll1 || a == OFS_FP_DATA0 || a == OFS_FP_DATA1) begin
			s = SEL_FP_DATA;
		end else begin
			s = SEL_FP_ADDR;
		end
		return s;
	endfunction

	logic [SYNC_W-1:0] syncIn;
	logic [SYNC_W-1:0] syncOut;
	logic              csS;
	logic              rdS;
	logic              wrS;
	logic [2:0]        addrS;
	logic [7:0]        hostDataS;
	logic [7:0]        portDataS;
	logic              busyS;
	logic              ackS;
	logic              paperS;
	logic              selectS;
	logic              errorS;
	logic              bidirS;

	assign syncIn = {port_chip_select_n, ioReadN, ioWriteN, addr, hostDataIn, portDataIn,
		busyPin, ackPinN, paperEnd, printerSelected, errorPin, bidirEnablePin};

	ppr_sync #(
		.WIDTH (SYNC_W)
	) u_sync (
		.mclk (mclk),
		.srst (srst),
		.din  (syncIn),
		.dout (syncOut)
	);

	assign {csS, rdS, wrS, addrS, hostDataS, portDataS,
		busyS, ackS, paperS, selectS, errorS, bidirS} = syncOut;

	logic       wrPrev_reg;
	logic       wrPrev_next;
	logic [7:0] data_reg;
	logic [7:0] data_next;
	logic [5:0] ctl_reg;
	logic [5:0] ctl_next;
	logic [7:0] index_reg;
	logic [7:0] index_next;
	logic [7:0] fpData_reg;
	logic [7:0] fpData_next;
	logic [7:0] fpAddr_reg;
	logic [7:0] fpAddr_next;
	logic       stsInt_reg;
	logic       stsInt_next;
	logic [7:0] hostOut_reg;
	logic [7:0] hostOut_next;
	logic       hostOe_reg;
	logic       hostOe_next;
	logic       portOe_reg;
	logic       portOe_next;
	logic       irq_reg;
	logic       irq_next;
	logic       fpEn_reg;
	logic       fpEn_next;

	logic [7:0] modeSel;
	logic [7:0] bankRd;
	logic       fpOn;
	logic       idxAll1;
	logic       intSignal;
	logic       wrStrobe;
	logic       rdActive;
	logic       bankWr;
	logic [7:0] statusByte;
	logic [7:0] controlByte;
	ppr_sel_t   sel;

	assign fpOn      = modeSel[MODE_FPEN_BIT];
	assign idxAll1   = (index_reg[2:0] == IDX_PARK);
	assign sel       = decodeSel(addrS, fpOn, idxAll1);
	// strobe edge taken once per write, only with chip select low
	assign wrStrobe  = !csS && rdS && !wrS && wrPrev_reg;
	assign rdActive  = !csS && !rdS && wrS;
	assign bankWr    = wrStrobe && (sel == SEL_INDIRECT);
	// acknowledge pulse from the printer is the interrupt source
	assign intSignal = !ackS;

	ppr_indirect_bank #(
		.VERSION_VALUE (VERSION_VALUE)
	) u_bank (
		.mclk    (mclk),
		.srst    (srst),
		.wrPulse (bankWr),
		.index   (index_reg[2:0]),
		.wrData  (hostDataS),
		.rdData  (bankRd),
		.modeSel (modeSel)
	);

	assign statusByte  = {busyS, ackS, paperS, selectS, errorS, stsInt_reg, STS_LOW_ONES};
	assign controlByte = {CTL_READ_ONES, ctl_reg[CTL_IRQEN_BIT:0]};

	always_comb begin
		wrPrev_next  = wrS;
		data_next    = data_reg;
		ctl_next     = ctl_reg;
		index_next   = index_reg;
		fpData_next  = fpData_reg;
		fpAddr_next  = fpAddr_reg;
		fpEn_next    = fpOn;
		// bit 2 shows the interrupt only in the alternate interrupt mode
		stsInt_next  = modeSel[MODE_INTSEL_BIT] ? intSignal : 1'b1;
		irq_next     = ctl_reg[CTL_IRQEN_BIT] && intSignal;
		// receive only with pin high and, in extended mode, direction bit set
		portOe_next  = !bidirS || (modeSel[MODE_EXT_BIT] && !ctl_reg[CTL_DIR_BIT]);
		hostOe_next  = rdActive;
		hostOut_next = hostOut_reg;
		if (wrStrobe) begin
			case (sel)
				SEL_DATA: begin
					data_next = hostDataS;
				end
				SEL_CONTROL: begin
					ctl_next = hostDataS[CTL_DIR_BIT:0];
				end
				SEL_INDEX: begin
					index_next = hostDataS;
				end
				SEL_FP_DATA: begin
					fpData_next = hostDataS;
				end
				SEL_FP_ADDR: begin
					fpAddr_next = hostDataS;
				end
				default: begin
				end
			endcase
		end
		if (rdActive) begin
			case (sel)
				SEL_DATA: begin
					hostOut_next = portOe_reg ? data_reg : portDataS;
				end
				SEL_STATUS: begin
					hostOut_next = statusByte;
				end
				SEL_CONTROL: begin
					hostOut_next = controlByte;
				end
				SEL_INDEX: begin
					hostOut_next = index_reg;
				end
				SEL_FP_DATA: begin
					hostOut_next = fpData_reg;
				end
				SEL_FP_ADDR: begin
					hostOut_next = fpAddr_reg;
				end
				default: begin
					hostOut_next = bankRd;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			wrPrev_reg  <= 1'b1;
			data_reg    <= DATA_RESET;
			ctl_reg     <= CTL_RESET;
			index_reg   <= INDEX_RESET;
			fpData_reg  <= FP_RESET;
			fpAddr_reg  <= FP_RESET;
			stsInt_reg  <= 1'b0;
			hostOut_reg <= DATA_RESET;
			hostOe_reg  <= 1'b0;
			portOe_reg  <= 1'b0;
			irq_reg     <= 1'b0;
			fpEn_reg    <= 1'b0;
		end else begin
			wrPrev_reg  <= wrPrev_next;
			data_reg    <= data_next;
			ctl_reg     <= ctl_next;
			index_reg   <= index_next;
			fpData_reg  <= fpData_next;
			fpAddr_reg  <= fpAddr_next;
			stsInt_reg  <= stsInt_next;
			hostOut_reg <= hostOut_next;
			hostOe_reg  <= hostOe_next;
			portOe_reg  <= portOe_next;
			irq_reg     <= irq_next;
			fpEn_reg    <= fpEn_next;
		end
	end

	assign hostDataOut    = hostOut_reg;
	assign hostDataOe     = hostOe_reg;
	assign portDataOut    = data_reg;
	assign portDataOe     = portOe_reg;
	assign lineStrobe     = ctl_reg[CTL_STROBE_BIT];
	assign lineAutofeed   = ctl_reg[CTL_AUTOFD_BIT];
	assign lineInitialize = ctl_reg[CTL_INIT_BIT];
	assign lineSelectIn   = ctl_reg[CTL_SELIN_BIT];
	assign portIrq        = irq_reg;
	assign fastPortEnable = fpEn_reg;

	csIdle_a: assert property (@(posedge mclk) disable iff (srst)
		csS |=> $stable(data_reg) && $stable(ctl_reg) && $stable(index_reg))
		else $error("register changed with chip select high");

	imageWrite_a: assert property (@(posedge mclk) disable iff (srst)
		wrStrobe && !fpOn && addrS == OFS_FP_DATA0 |=> data_reg == $past(hostDataS))
		else $error("offset 4 did not alias data with fast port off");

	fpAddrWrite_a: assert property (@(posedge mclk) disable iff (srst)
		wrStrobe && fpOn && !idxAll1 && addrS == OFS_FP_ADDR |=> fpAddr_reg == $past(hostDataS))
		else $error("fast port address write lost");

	fpParkWrite_a: assert property (@(posedge mclk) disable iff (srst)
		wrStrobe && fpOn && idxAll1 && addrS == OFS_INDIRECT |=> fpData_reg == $past(hostDataS))
		else $error("offset 7 did not reach fast port data with index parked");

	fpGate_a: assert property (@(posedge mclk) disable iff (srst)
		!modeSel[MODE_FPEN_BIT] |-> sel != SEL_FP_DATA && sel != SEL_FP_ADDR)
		else $error("fast port decoded while disabled");

	statusWrite_a: assert property (@(posedge mclk) disable iff (srst)
		wrStrobe && sel == SEL_STATUS |=> $stable(data_reg) && $stable(ctl_reg) && $stable(index_reg))
		else $error("status write had an effect");

	statusInt_a: assert property (@(posedge mclk) disable iff (srst)
		rdActive && sel == SEL_STATUS && !modeSel[MODE_INTSEL_BIT] ##1 rdActive && sel == SEL_STATUS
		|=> hostOut_reg[STS_INT_BIT])
		else $error("status bit 2 not one outside interrupt mode");

	statusLow_a: assert property (@(posedge mclk) disable iff (srst)
		rdActive && sel == SEL_STATUS |=> hostOe_reg && hostOut_reg[1:0] == STS_LOW_ONES)
		else $error("status low bits not ones");

	ctlReset_a: assert property (@(posedge mclk)
		srst |=> ctl_reg == CTL_RESET && !lineStrobe && !portIrq)
		else $error("control not cleared by reset");

	ctlRead_a: assert property (@(posedge mclk) disable iff (srst)
		rdActive && sel == SEL_CONTROL |=> hostOut_reg[7:5] == CTL_READ_ONES
		&& hostOut_reg[4:0] == $past(ctl_reg[4:0]))
		else $error("control read back wrong");

	irqOff_a: assert property (@(posedge mclk) disable iff (srst)
		!ctl_reg[CTL_IRQEN_BIT] |=> !portIrq)
		else $error("interrupt raised while disabled");

	driveLow_a: assert property (@(posedge mclk) disable iff (srst)
		!bidirS |=> portDataOe)
		else $error("port not driving with bidirectional pin low");

	compatRecv_a: assert property (@(posedge mclk) disable iff (srst)
		bidirS && !modeSel[MODE_EXT_BIT] |=> !portDataOe)
		else $error("compatible mode drove with bidirectional pin high");

	indexWrite_a: assert property (@(posedge mclk) disable iff (srst)
		wrStrobe && addrS == OFS_INDEX |=> index_reg == $past(hostDataS))
		else $error("index register write lost");
endmodule
`default_nettype wire

/* File: test/ppr_printer_model.sv */
// printer cable model: status pins and the printer side of the data bus
// assumes the bench resolves the data wire from both drivers
`timescale 1ns/1ps
`default_nettype none
module ppr_printer_model (
	input  wire logic       mclk,
	input  wire logic [4:0] pinSet,
	input  wire logic [7:0] padData,
	input  wire logic       portDataOe,
	output logic            busyPin,
	output logic            ackPinN,
	output logic            paperEnd,
	output logic            printerSelected,
	output logic            errorPin,
	output logic [7:0]      modelData
);
	logic [7:0] spin = 8'h00;
	always @(posedge mclk) spin <= spin + 8'h01;
	assign {busyPin, ackPinN, paperEnd, printerSelected, errorPin} = pinSet;
	// released bus shows padData; while the port drives, a changing pattern
	assign modelData = portDataOe ? ~padData ^ spin : padData;
endmodule
`default_nettype wire

/* File: test/printer_parallel_port_regs_tb_top.sv */
// self-checking bench of the parallel port register block
// assumes one 125 MHz clock; reads are scored by a queue monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module printer_parallel_port_regs_tb_top;
	import ppr_pkg::*;
	logic       mclk, srst, csN, ioReadN, ioWriteN, bidir;
	logic       oePrev = 1'b0;
	logic [2:0] addr;
	logic [7:0] hostDataIn, hostDataOut, portDataIn, portDataOut, modelData, padData, d, e;
	logic       hostDataOe, portDataOe, busyPin, ackPinN, paperEnd, printerSelected, errorPin;
	logic       lineStrobe, lineAutofeed, lineInitialize, lineSelectIn, portIrq, fastPortEnable;
	logic [4:0] pins;
	logic [31:0] seed = 32'h0000000E;
	logic [7:0] expQ[$];
	int         n_fail = 0;
	int         check_count = 0;
	assign portDataIn = portDataOe ? portDataOut : modelData;
	ppr_port_regs uut (.mclk(mclk), .srst(srst), .port_chip_select_n(csN), .ioReadN(ioReadN),
		.ioWriteN(ioWriteN), .addr(addr), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
		.hostDataOe(hostDataOe), .portDataIn(portDataIn), .portDataOut(portDataOut),
		.portDataOe(portDataOe), .busyPin(busyPin), .ackPinN(ackPinN), .paperEnd(paperEnd),
		.printerSelected(printerSelected), .errorPin(errorPin), .bidirEnablePin(bidir),
		.lineStrobe(lineStrobe), .lineAutofeed(lineAutofeed), .lineInitialize(lineInitialize),
		.lineSelectIn(lineSelectIn), .portIrq(portIrq), .fastPortEnable(fastPortEnable));
	ppr_printer_model prn (.mclk(mclk), .pinSet(pins), .padData(padData), .portDataOe(portDataOe),
		.busyPin(busyPin), .ackPinN(ackPinN), .paperEnd(paperEnd),
		.printerSelected(printerSelected), .errorPin(errorPin), .modelData(modelData));
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic test_done();
		if (n_fail == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] v, input logic c = 1'b0);
		@(negedge mclk);
		csN = c;
		addr = a;
		hostDataIn = v;
		ioWriteN = 1'b0;
		repeat (4) @(negedge mclk);
		ioWriteN = 1'b1;
		repeat (4) @(negedge mclk);
		csN = 1'b1;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] x);
		expQ.push_back(x);
		@(negedge mclk);
		csN = 1'b0;
		addr = a;
		ioReadN = 1'b0;
		repeat (5) @(negedge mclk);
		ioReadN = 1'b1;
		repeat (5) @(negedge mclk);
		csN = 1'b1;
	endtask
	task automatic waitc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// read monitor: first cycle of an answer takes the oldest note
	always @(negedge mclk) begin
		if (hostDataOe === 1'b1 && !oePrev) begin
			if (expQ.size() == 0) begin
				n_fail++;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, hostDataOut, 8'h00);
			end else begin
				e = expQ.pop_front();
				`CHK(hostDataOut, e)
			end
		end
		oePrev = (hostDataOe === 1'b1);
	end
	initial begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		test_done();
	end
	initial begin
		logic [31:0] r;
		logic        expOe;
		srst = 1'b1; csN = 1'b1; ioReadN = 1'b1; ioWriteN = 1'b1; addr = 3'h0;
		hostDataIn = 8'h00; pins = 5'h1F; bidir = 1'b0; padData = 8'h00; d = 8'h00;
		repeat (3) @(negedge mclk);
		srst = 1'b0;
		waitc(3);
		rd(3'h0, 8'h00);
		rd(3'h2, 8'hE0);
		rd(3'h3, 8'h00);
		rd(3'h1, {pins, 3'h7});
		for (int i = 0; i < 6; i++) begin
			r = rnd();
			pins = r[4:0];
			d = r[15:8];
			wr({r[16], 2'h0}, d);
			rd({~r[16], 2'h0}, d);
			wr({r[17], 2'h1}, ~d);
			rd({r[18], 2'h1}, {pins, 3'h7});
		end
		wr(3'h0, ~d, 1'b1);
		rd(3'h0, d);
		`CHK(portDataOut, d)
		wr(3'h6, 8'hFF);
		`CHK({lineSelectIn, lineInitialize, lineAutofeed, lineStrobe}, 4'hF)
		rd(3'h2, 8'hFF);
		// strobe, autofeed and select-in cleared before fast port traffic
		wr(3'h2, 8'h04);
		`CHK({lineSelectIn, lineInitialize, lineAutofeed, lineStrobe}, 4'h4)
		rd(3'h6, 8'hE4);
		wr(3'h3, 8'h05);
		wr(3'h7, 8'h16);
		rd(3'h7, 8'h16);
		rd(3'h3, 8'h05);
		`CHK(fastPortEnable, 1'b1)
		wr(3'h4, 8'hA5);
		rd(3'h5, 8'hA5);
		rd(3'h0, d);
		wr(3'h6, 8'h3C);
		rd(3'h6, 8'h3C);
		wr(3'h3, 8'h07);
		rd(3'h6, 8'hA5);
		wr(3'h7, 8'h77);
		rd(3'h4, 8'h77);
		rd(3'h2, 8'hE4);
		wr(3'h3, 8'h05);
		wr(3'h2, 8'h14);
		pins[3] = 1'b0;
		waitc(4);
		`CHK(portIrq, 1'b1)
		rd(3'h1, {pins, 3'h7});
		pins[3] = 1'b1;
		waitc(4);
		`CHK(portIrq, 1'b0)
		rd(3'h1, {pins, 3'h3});
		pins[3] = 1'b0;
		wr(3'h2, 8'h04);
		`CHK(portIrq, 1'b0)
		for (int k = 0; k < 8; k++) begin
			r = rnd();
			padData = r[7:0];
			wr(3'h7, k[2] ? 8'h16 : 8'h14);
			wr(3'h2, {2'h0, k[0], 5'h04});
			bidir = k[1];
			waitc(4);
			expOe = ~k[1] | (k[2] & ~k[0]);
			`CHK(portDataOe, expOe)
			rd(3'h0, expOe ? d : padData);
		end
		bidir = 1'b0;
		wr(3'h7, 8'h00);
		`CHK(fastPortEnable, 1'b0)
		wr(3'h4, 8'h99);
		rd(3'h0, 8'h99);
		rd(3'h7, 8'h00);
		// parking and version slots: reads fixed, writes dropped
		wr(3'h3, 8'h07);
		wr(3'h7, 8'h10);
		rd(3'h7, PARK_READ);
		wr(3'h3, 8'h06);
		wr(3'h7, 8'h10);
		rd(3'h7, 8'h5A);
		wr(3'h3, 8'h05);
		rd(3'h7, 8'h00);
		`CHK(fastPortEnable, 1'b0)
		test_done();
	end
endmodule
`default_nettype wire
